// ===== logic/adc_chain_defines.svh
`ifndef ADC_CHAIN_DEFINES_SVH
`define ADC_CHAIN_DEFINES_SVH

// number of converter channels and their index width
`define CH_NUM          16
`define CH_W            4
`define CH_IDX_W        5
// converted data width
`define DATA_W          12
// clock period and analogue phase times
`define CLK_PERIOD_NS   5
`define SAMPLE_TIME_NS  30
`define CONV_TIME_NS    60
// width of the conversion phase counter
`define PHASE_CNT_W     8
// state machine codes
`define ST_IDLE_CODE    2'h0
`define ST_NORMAL_CODE  2'h1
`define ST_INJ_CODE     2'h2

`endif

// ===== logic/adc_chain_pkg.sv
`default_nettype none
`include "adc_chain_defines.svh"

package adc_chain_pkg;

  // sequencer state codes
  typedef enum logic [1:0] {
    ST_IDLE   = `ST_IDLE_CODE,
    ST_NORMAL = `ST_NORMAL_CODE,
    ST_INJ    = `ST_INJ_CODE
  } seq_state_t;

  // software control and configuration bits
  typedef struct packed {
    logic                normal_chain_start;
    logic                scan_mode;
    logic                cross_trigger_unit;
    logic                dma_enable;
    logic                dma_clear_on_read;
    logic [`CH_NUM-1:0]  normal_mask;
    logic [`CH_NUM-1:0]  inj_mask;
  } chain_cfg_t;

  // full state of the sequencer
  typedef struct packed {
    seq_state_t                      state;
    logic [`CH_W-1:0]                ch;
    logic                            inj_pend;
    logic                            resume;
    logic [`CH_W-1:0]                resume_ch;
    logic                            abort;
    logic                            dma_req;
    logic [`CH_NUM-1:0]              valid;
    logic [`DATA_W-1:0]              rd_data;
    logic [`CH_NUM-1:0][`DATA_W-1:0] result;
  } seq_reg_t;

  // state of the conversion phase timer
  typedef struct packed {
    logic                    busy;
    logic [`PHASE_CNT_W-1:0] cnt;
  } timer_reg_t;

endpackage
`default_nettype wire

// ===== logic/conv_phase_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_chain_defines.svh"

module conv_phase_timer #(
  parameter int SAMPLE_CYC = (`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int CONV_CYC   = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // control from the sequencer
  input  wire logic start_i,
  input  wire logic abort_i,
  // phase status
  output logic      busy_o,
  output logic      sampling_o,
  output logic      done_o
);
  import adc_chain_pkg::*;

  localparam logic [`PHASE_CNT_W-1:0] LAST = `PHASE_CNT_W'(SAMPLE_CYC + CONV_CYC - 1);
  localparam logic [`PHASE_CNT_W-1:0] CONV = `PHASE_CNT_W'(CONV_CYC);

  timer_reg_t q;       // registered state
  timer_reg_t next_q;  // next state

  // a start always wins, so the sequencer can abort and relaunch in one cycle
  always_comb begin
    next_q = q;
    if (start_i) begin
      next_q.busy = 1'b1;
      next_q.cnt  = LAST;
    end else if (q.busy) begin
      if (abort_i || q.cnt == '0) begin
        next_q.busy = 1'b0;
      end else begin
        next_q.cnt = q.cnt - 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign busy_o     = q.busy;
  assign sampling_o = q.busy && (q.cnt >= CONV);
  // done must not look at start or abort: the sequencer derives both from done, which would close a loop;
  // the sequencer itself gives an abort in the last cycle priority over the result write
  assign done_o     = q.busy && (q.cnt == '0);

endmodule
`default_nettype wire

// ===== logic/adc_chain_abort_control.sv
// Summary of operation
// (R1) single abort cancels one, chain continues
// (R2) aborted final conversion leaves result untouched
// (R3) chain abort stops, writes no data
// (R4) injected requests run, then chain resumes
// (R5) next scan converts each channel once
// (R6) software clears start with chain abort
// (R7) dma request held until results read; with dma_clear_on_read off, dma_ack_i withdraws it instead
// (R8) software programs at least two conversions
// (R9) chain abort bit self-clears when done
`timescale 1ns/10ps
`default_nettype none
`include "adc_chain_defines.svh"

module adc_chain_abort_control #(
  parameter int SAMPLE_CYC = (`SAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int CONV_CYC   = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     srst_i,
  // software control
  input  wire adc_chain_pkg::chain_cfg_t cfg_i,
  input  wire logic                     injected_chain_start_i,
  input  wire logic                     inj_timer_trigger_i,
  input  wire logic                     single_abort_i,
  input  wire logic                     chain_abort_set_i,
  // analogue result
  input  wire logic [`DATA_W-1:0]       adc_data_i,
  // result readout and dma
  input  wire logic                     rd_strobe_i,
  input  wire logic [`CH_W-1:0]         rd_ch_i,
  input  wire logic                     dma_ack_i,
  // status
  output logic [`DATA_W-1:0]            rd_data_o,
  output logic [`CH_NUM-1:0]            data_valid_o,
  output logic                          dma_req_o,
  output logic                          chain_abort_request_o,
  output logic                          busy_o,
  output logic                          injected_active_o,
  output logic                          sampling_o,
  output logic [`CH_W-1:0]              cur_ch_o
);
  import adc_chain_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // next enabled channel at or above a start index; msb flags a hit
  function automatic logic [`CH_IDX_W-1:0] find_ch(input logic [`CH_NUM-1:0] mask,
                                                   input logic [`CH_IDX_W-1:0] from);
    logic [`CH_IDX_W-1:0] res;
    res = '0;
    for (int i = `CH_NUM - 1; i >= 0; i--) begin
      if (mask[i] && (`CH_IDX_W'(i) >= from)) begin
        res = {1'b1, `CH_W'(i)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  seq_reg_t             q;          // registered state
  seq_reg_t             next_q;     // next state
  logic                 conv_start; // launch a conversion on next_q.ch
  logic                 conv_abort; // cancel the running conversion
  logic                 conv_done;  // running conversion finished
  logic                 conv_busy;  // timer running
  logic [`CH_IDX_W-1:0] norm_next;  // continuation of the normal chain
  logic [`CH_IDX_W-1:0] norm_cont;  // next enabled normal channel above the current one
  logic [`CH_IDX_W-1:0] norm_first; // first enabled normal channel
  logic [`CH_IDX_W-1:0] inj_next;   // next injected channel
  logic [`CH_IDX_W-1:0] inj_first;  // first injected channel
  logic [`DATA_W-1:0]   cur_result; // stored result of the current channel
  logic                 scan_on;    // scan wrap permitted

  conv_phase_timer #(
    .SAMPLE_CYC (SAMPLE_CYC),
    .CONV_CYC   (CONV_CYC)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .start_i    (conv_start),
    .abort_i    (conv_abort),
    .busy_o     (conv_busy),
    .sampling_o (sampling_o),
    .done_o     (conv_done)
  );

  assign cur_result = q.result[q.ch];
  assign scan_on    = cfg_i.normal_chain_start && cfg_i.scan_mode && !cfg_i.cross_trigger_unit;
  assign inj_first  = find_ch(cfg_i.inj_mask, '0);
  assign inj_next   = find_ch(cfg_i.inj_mask, `CH_IDX_W'(q.ch) + 1'b1);
  assign norm_first = find_ch(cfg_i.normal_mask, '0);
  assign norm_cont  = find_ch(cfg_i.normal_mask, `CH_IDX_W'(q.ch) + 1'b1);

  // (R5) fresh scan restart
  // wrapping always restarts from the first enabled channel, so nothing repeats
  always_comb begin
    norm_next = norm_cont;
    if (!norm_cont[`CH_W] && scan_on) begin
      norm_next = norm_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    next_q     = q;
    conv_start = 1'b0;
    conv_abort = 1'b0;
    // dma withdrawal: on read when clear-on-read is set, else on acknowledge
    // (R7) held until read
    if (cfg_i.dma_clear_on_read ? rd_strobe_i : dma_ack_i) begin
      next_q.dma_req = 1'b0;
    end
    if (rd_strobe_i) begin
      next_q.rd_data          = q.result[rd_ch_i];
      next_q.valid[rd_ch_i]   = 1'b0;
    end
    unique case (q.state)
      ST_IDLE: begin
        // (R9) abort bit clears
        next_q.abort  = 1'b0;
        next_q.resume = 1'b0;
        if (q.inj_pend) begin
          next_q.inj_pend = 1'b0;
          if (inj_first[`CH_W]) begin
            next_q.state = ST_INJ;
            next_q.ch    = inj_first[`CH_W-1:0];
            conv_start   = 1'b1;
          end
        end else if (cfg_i.normal_chain_start && !q.abort && norm_first[`CH_W]) begin
          next_q.state = ST_NORMAL;
          next_q.ch    = norm_first[`CH_W-1:0];
          conv_start   = 1'b1;
        end
      end
      ST_NORMAL, ST_INJ: begin
        if (q.abort) begin
          // (R3) whole chain stops
          // the result write below is skipped, the register keeps old data
          conv_abort    = 1'b1;
          next_q.state  = ST_IDLE;
          next_q.resume = 1'b0;
          // (R9) abort bit clears
          next_q.abort  = 1'b0;
        end else if (single_abort_i || conv_done) begin
          // (R2) discard aborted result
          // only a finished conversion writes, even for the last channel
          if (conv_done && !single_abort_i) begin
            next_q.result[q.ch] = adc_data_i;
            next_q.valid[q.ch]  = 1'b1;
            next_q.dma_req      = next_q.dma_req | cfg_i.dma_enable;
          end
          conv_abort = single_abort_i;
          if (q.state == ST_INJ) begin
            if (inj_next[`CH_W]) begin
              next_q.ch  = inj_next[`CH_W-1:0];
              conv_start = 1'b1;
            end else if (q.resume) begin
              // (R4) chain resumes
              next_q.state  = ST_NORMAL;
              next_q.ch     = q.resume_ch;
              next_q.resume = 1'b0;
              conv_start    = 1'b1;
            end else begin
              next_q.state = ST_IDLE;
            end
          end else if (q.inj_pend && inj_first[`CH_W]) begin
            // (R4) injected preempts chain
            // the normal continuation is parked and picked up afterwards
            next_q.inj_pend  = 1'b0;
            next_q.state     = ST_INJ;
            next_q.ch        = inj_first[`CH_W-1:0];
            next_q.resume    = norm_next[`CH_W];
            next_q.resume_ch = norm_next[`CH_W-1:0];
            conv_start       = 1'b1;
          end else if (norm_next[`CH_W]) begin
            // (R1) chain continues
            next_q.ch  = norm_next[`CH_W-1:0];
            conv_start = 1'b1;
          end else begin
            next_q.state = ST_IDLE;
          end
        end
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase
    // events arriving now win over any clear above
    if (injected_chain_start_i || inj_timer_trigger_i) begin
      next_q.inj_pend = 1'b1;
    end
    if (chain_abort_set_i) begin
      next_q.abort = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rd_data_o             = q.rd_data;
  assign data_valid_o          = q.valid;
  assign dma_req_o             = q.dma_req;
  assign chain_abort_request_o = q.abort;
  assign busy_o                = (q.state != ST_IDLE);
  assign injected_active_o     = (q.state == ST_INJ);
  assign cur_ch_o              = q.ch;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the sequencer
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_single_abort_keep: assert property ( // (R2)
    (q.state != ST_IDLE && !q.abort && single_abort_i)
      |=> q.result[$past(q.ch)] == $past(cur_result)) else $error("aborted conversion wrote data");
  a_single_abort_go: assert property ( // (R1)
    (q.state == ST_NORMAL && !q.abort && single_abort_i && !q.inj_pend && norm_next[`CH_W])
      |=> q.state == ST_NORMAL && conv_busy) else $error("single abort stopped the chain");
  a_chain_abort_stop: assert property ( // (R3)
    (q.state != ST_IDLE && q.abort) |=> q.state == ST_IDLE && !conv_busy && $stable(q.result))
    else $error("chain abort left conversion or data");
  a_abort_bit_clear: assert property ( // (R9)
    (q.abort && !chain_abort_set_i) |-> ##[1:2] !q.abort) else $error("abort bit not cleared");
  a_inj_preempt: assert property ( // (R4)
    (q.state == ST_NORMAL && !q.abort && conv_done && !single_abort_i && q.inj_pend && inj_first[`CH_W])
      |=> q.state == ST_INJ) else $error("injected request not executed");
  a_inj_resume: assert property ( // (R4)
    (q.state == ST_INJ && !q.abort && conv_done && !single_abort_i && !inj_next[`CH_W] && q.resume)
      |=> q.state == ST_NORMAL && q.ch == $past(q.resume_ch)) else $error("chain not resumed");
  a_scan_wrap: assert property ( // (R5)
    (q.state == ST_NORMAL && !q.abort && conv_done && !q.inj_pend && scan_on &&
     !norm_cont[`CH_W] && norm_first[`CH_W])
      |=> q.ch == $past(norm_first[`CH_W-1:0]) && conv_busy) else $error("scan wrap wrong");
  a_dma_hold: assert property ( // (R7)
    (q.dma_req && cfg_i.dma_clear_on_read && !rd_strobe_i) |=> q.dma_req)
    else $error("dma request withdrawn before read");
  a_dma_read_clear: assert property ( // (R7)
    (q.dma_req && cfg_i.dma_clear_on_read && rd_strobe_i && !conv_done) |=> !q.dma_req)
    else $error("dma request kept after read");

  c_chain_abort: cover property (q.state == ST_NORMAL && q.abort ##1 q.state == ST_IDLE);
  c_inj_in_scan: cover property (q.state == ST_INJ && q.resume ##[1:200] q.state == ST_NORMAL);
  c_single_abort: cover property (q.state == ST_NORMAL && single_abort_i);
  c_dma_read: cover property (q.dma_req && cfg_i.dma_clear_on_read && rd_strobe_i);

endmodule
`default_nettype wire

// ===== dv/tb_adc_chain_abort_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_chain_defines.svh"

module tb_adc_chain_abort_control;
  import adc_chain_pkg::*;

  // stimulus toward the sequencer
  logic               clk, srst, inj_sw, inj_tmr, sab, cab, rd_stb, dma_ack;
  chain_cfg_t         cfg;
  logic [`DATA_W-1:0] adc_data;
  logic [`CH_W-1:0]   rd_ch;
  // observed outputs
  logic [`DATA_W-1:0] rd_data;
  logic [`CH_NUM-1:0] valid;
  logic [`CH_W-1:0]   cur_ch;
  logic               dma_req, cab_o, busy, inj_act, samp;
  // bookkeeping
  int                 bad_count, num_checks, i, k;
  logic [`CH_W-1:0]   seq_q[$];

  // short phases keep the run brief; all waits are bounded anyway
  adc_chain_abort_control #(.SAMPLE_CYC(2), .CONV_CYC(2)) dut (
    .core_clk_i(clk), .srst_i(srst), .cfg_i(cfg),
    .injected_chain_start_i(inj_sw), .inj_timer_trigger_i(inj_tmr),
    .single_abort_i(sab), .chain_abort_set_i(cab), .adc_data_i(adc_data),
    .rd_strobe_i(rd_stb), .rd_ch_i(rd_ch), .dma_ack_i(dma_ack),
    .rd_data_o(rd_data), .data_valid_o(valid), .dma_req_o(dma_req),
    .chain_abort_request_o(cab_o), .busy_o(busy), .injected_active_o(inj_act),
    .sampling_o(samp), .cur_ch_o(cur_ch));

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // analogue value carries its channel, so a stray write is traceable
  always @(negedge clk) adc_data <= {8'hA5, cur_ch};

  ////////////////////////////////////////////////////////////////////////////
  // value compare
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // a wait that ran out counts as a mismatch and ends the run
  task automatic give_up;
    bad_count++;
    $display("[ERR] wait expected done seen hang");
    tally_and_finish();
  endtask

  // wait until a given channel is being converted
  task automatic wait_ch(input logic [3:0] ch);
    int j;
    for (j = 0; j < 300 && !(busy === 1'b1 && cur_ch === ch); j++) cyc(1);
    if (!(busy === 1'b1 && cur_ch === ch)) give_up();
  endtask

  task automatic wait_idle;
    int j;
    for (j = 0; j < 300 && busy !== 1'b0; j++) cyc(1);
    if (busy !== 1'b0) give_up();
  endtask

  // read one result register; data lands the cycle after the strobe and holds,
  // and the strobe rests low for a cycle so back-to-back reads stay distinct
  task automatic rd(input logic [3:0] ch, input logic [11:0] e);
    rd_ch  = ch;
    rd_stb = 1'b1;
    cyc(1);
    rd_stb = 1'b0;
    cyc(1);
    chk("rd_data", {4'h0, e}, {4'h0, rd_data});
    chk("valid_after_read", 16'h0000, {15'h0, valid[ch]});
  endtask

  // start a chain; one-shot chains drop the start bit once running
  task automatic run(input logic [15:0] m, input logic scan);
    cfg.normal_mask        = m;
    cfg.scan_mode          = scan;
    cfg.normal_chain_start = 1'b1;
    cyc(2);
    if (!scan) cfg.normal_chain_start = 1'b0;
  endtask

  // chain abort written together with clearing the start bit
  task automatic stop_chain;
    cab                    = 1'b1;
    cfg.normal_chain_start = 1'b0;
    cyc(1);
    cab = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cfg = '0;
    {srst, inj_sw, inj_tmr, sab, cab, rd_stb, dma_ack} = 7'h40;
    rd_ch = 4'h0;
    bad_count = 0;
    num_checks = 0;
    cfg.dma_enable = 1'b1;
    cfg.dma_clear_on_read = 1'b1;
    cyc(8);
    chk("reset_outputs", 16'h0000, {12'h0, busy, dma_req, cab_o, inj_act});
    srst = 1'b0;

    // plain one-shot chain, then dma request kept until a read
    run(16'h0006, 1'b0);
    chk("sampling", 16'h0001, {15'h0, samp});
    cyc(1);
    chk("converting", 16'h0000, {15'h0, samp});
    wait_idle();
    cyc(10);
    chk("valid_1_2", 16'h0006, valid & 16'h0006);
    dma_ack = 1'b1;
    cyc(1);
    dma_ack = 1'b0;
    chk("dma_req_held", 16'h0001, {15'h0, dma_req});
    rd(4'h1, 12'hA51);
    chk("dma_req_cleared", 16'h0000, {15'h0, dma_req});
    rd(4'h2, 12'hA52);

    // single abort in mid-chain cancels one conversion only
    run(16'h0038, 1'b0);
    wait_ch(4'h4);
    sab = 1'b1;
    cyc(1);
    sab = 1'b0;
    chk("next_ch_after_abort", 16'h0005, {12'h0, cur_ch});
    wait_idle();
    chk("valid_3_4_5", 16'h0028, valid & 16'h0038);
    rd(4'h4, 12'h000);

    // abort of the final conversion leaves its result alone
    run(16'h00C0, 1'b0);
    wait_ch(4'h7);
    sab = 1'b1;
    cyc(1);
    sab = 1'b0;
    wait_idle();
    chk("valid_6_7", 16'h0040, valid & 16'h00C0);
    rd(4'h7, 12'h000);

    // chain abort in scan mode stops at once and self-clears
    run(16'h0300, 1'b1);
    wait_ch(4'h8);
    stop_chain();
    chk("abort_bit_set", 16'h0001, {15'h0, cab_o});
    cyc(1);
    chk("abort_done", 16'h0000, {14'h0, cab_o, busy});
    chk("valid_8", 16'h0000, {15'h0, valid[8]});
    rd(4'h8, 12'h000);

    // next scan after an abort runs each channel once, in order
    run(16'h1C00, 1'b1);
    wait_ch(4'hB);
    stop_chain();
    cyc(3);
    cfg.normal_chain_start = 1'b1;
    for (i = 0; i < 300 && seq_q.size() < 4; i++) begin
      cyc(1);
      if (busy === 1'b1 && (seq_q.size() == 0 || seq_q[$] !== cur_ch)) seq_q.push_back(cur_ch);
    end
    if (seq_q.size() < 4) give_up();
    chk("scan_order", 16'hABCA, {seq_q[0], seq_q[1], seq_q[2], seq_q[3]});
    stop_chain();
    cyc(3);

    // injected request in scan mode, by software then by timer
    cfg.inj_mask = 16'h8000;
    for (k = 0; k < 2; k++) begin
      run(16'h6000, 1'b1);
      wait_ch(4'hE);
      inj_sw  = (k == 0);
      inj_tmr = (k == 1);
      cyc(1);
      {inj_sw, inj_tmr} = 2'b00;
      wait_ch(4'hF);
      chk("inj_active", 16'h0001, {15'h0, inj_act});
      for (i = 0; i < 300 && !(inj_act === 1'b0 && cur_ch !== 4'hF); i++) cyc(1);
      if (!(inj_act === 1'b0 && cur_ch !== 4'hF)) give_up();
      chk("chain_resumed", 16'h0001, {15'h0, busy});
      chk("resume_ch", 16'h000D, {12'h0, cur_ch});
      chk("inj_valid", 16'h0001, {15'h0, valid[15]});
      rd(4'hF, 12'hA5F);
      stop_chain();
      cyc(3);
    end

    // with clear-on-read off, the acknowledge withdraws the request instead
    cfg.dma_clear_on_read = 1'b0;
    run(16'h0003, 1'b0);
    wait_idle();
    chk("dma_req_set", 16'h0001, {15'h0, dma_req});
    dma_ack = 1'b1;
    cyc(1);
    dma_ack = 1'b0;
    chk("dma_req_acked", 16'h0000, {15'h0, dma_req});
    tally_and_finish();
  end

endmodule
`default_nettype wire
